// *** rtl/dpe_pkg.sv ***
`default_nettype none
package dpe_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_ISTAT = 8'h08;
	localparam logic [7:0] OFF_IMASK = 8'h0c;
	localparam logic [7:0] OFF_ECNT = 8'h10;

	// Control register layout, bit 0 upward
	localparam int unsigned CTRL_ECC_BIT = 0;
	localparam int unsigned CTRL_XACK_BIT = 1;
	localparam int unsigned CTRL_SYNC_A_BIT = 2;
	localparam int unsigned CTRL_SYNC_B_BIT = 3;
	localparam int unsigned CTRL_FAST_BIT = 4;
	localparam int unsigned CTRL_W = 5;

	typedef struct packed {
		logic fast;
		logic sync_b;
		logic sync_a;
		logic xack;
		logic ecc;
	} dpe_cfg_t;

	localparam dpe_cfg_t CTRL_RST = 5'h00;
	localparam dpe_cfg_t CFG_ECC_DEF = 5'h01;
	localparam dpe_cfg_t CFG_NON_DEF = 5'h00;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_ERR_BIT = 0;
	localparam int unsigned IRQ_UNC_BIT = 1;
	localparam int unsigned IRQ_INIT_BIT = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

	// Sequencing counts
	localparam logic [15:0] PROG_BITS = 16'h0005;
	localparam logic [15:0] WARM_CYCLES = 16'h0008;

	// Memory port request
	typedef struct packed {
		logic wr;
		logic req;
	} dpe_req_t;

	typedef enum logic [3:0] {
		ST_PROG = 4'h0,
		ST_WARM = 4'h1,
		ST_INIT = 4'h3,
		ST_IDLE = 4'h2,
		ST_ROW = 4'h6,
		ST_COL = 4'h7,
		ST_CHK = 4'h5,
		ST_WB = 4'h4,
		ST_DONE = 4'hc,
		ST_REF = 4'hd
	} dpe_state_t;
endpackage
`default_nettype wire

// *** rtl/dpe_ctrl.sv ***
`default_nettype none
// What this block does
// - Non-ECC: transfer ack marks data valid
// - ECC: config bit picks xack or ack
// - ECC: sync bit picks early or late ack
// - Non-ECC: early go, timing by sync bit
// - ECC: zero fill initialises memory after reset
// - ECC: latch strobe captures syndrome, makes checkbits
// - Byte mark disable during read or refresh
// - Also during init and 8-cycle warm-up
// - ECC: error log strobe pulse on error
// - No error log strobe during refresh
// - Lock shuts out the port not served
// - Correctable low suppresses write-back enable
// - Fast cycle: own address latch strobe, port A grants only
// - Strap high ECC default, low non-ECC
// - 8-cycle warm-up after programming bits
module dpe_ctrl import dpe_pkg::*; #(
	parameter logic [15:0] INIT_WORDS = 16'h0100
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire dpe_req_t port_a_req,
	input wire dpe_req_t port_b_req,
	input wire logic lock_in,
	input wire logic refresh_req,
	input wire logic whole_word_write_in,
	input wire logic error_detect_in,
	input wire logic correctable_in,
	input wire logic strap_program_in,
	output logic port_a_transfer_ack,
	output logic port_b_transfer_ack,
	output logic port_a_ecc_ack,
	output logic port_b_ecc_ack,
	output logic port_a_early_go,
	output logic port_b_early_go,
	output logic fast_addr_latch_strobe,
	output logic zero_fill_cmd,
	output logic check_latch_strobe,
	output logic all_bytes_out_enable,
	output logic error_log_strobe_b,
	output logic ram_write_en
);
	dpe_state_t st_r;
	dpe_state_t st_nxt;
	dpe_cfg_t cfg_r;
	dpe_cfg_t prog_word;
	logic [15:0] cnt_r;
	logic [CTRL_W-1:0] shift_r;
	logic [1:0] req;
	logic [1:0] blocked;
	logic [1:0] grant;
	logic [1:0] done_r;
	logic [1:0] ackd_r;
	logic [1:0] sync_sel;
	logic [1:0] ack_pulse;
	logic [1:0] go_pulse;
	logic [1:0] fin_pulse;
	logic cur_port_r;
	logic last_port_r;
	logic cur_wr_r;
	logic rmw_r;
	logic err_r;
	logic corr_r;
	logic lock_prev_r;
	logic lock_port_r;
	logic lock_owner;
	logic init_done_r;
	logic log_b_r;
	logic err_ev;
	logic unc_ev;
	logic init_ev;
	logic in_cycle;
	logic [IRQ_W-1:0] ist_r;
	logic [IRQ_W-1:0] imask_r;
	logic [IRQ_W-1:0] ev;
	logic [15:0] ecnt_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic wr_acc;
	logic setup;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Port requests, index 0 is port A
	assign req = {port_b_req.req & ~done_r[1], port_a_req.req & ~done_r[0]};
	assign sync_sel = {cfg_r.sync_b, cfg_r.sync_a};

	// Lock owner is the port in service when lock rose
	assign lock_owner = lock_prev_r ? lock_port_r : cur_port_r;
	assign blocked[0] = lock_in & lock_owner;
	assign blocked[1] = lock_in & ~lock_owner;

	// Round robin between ports that are free to go
	always_comb begin
		grant = 2'b00;
		if (st_r == ST_IDLE && !refresh_req) begin
			if (req[0] && !blocked[0] && (!req[1] || blocked[1] || last_port_r))
				grant = 2'b01;
			else if (req[1] && !blocked[1])
				grant = 2'b10;
		end
	end

	// Sequencer
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
		ST_PROG: if (cnt_r == PROG_BITS - 16'h0001) st_nxt = ST_WARM;
		ST_WARM: begin
			if (cnt_r == WARM_CYCLES - 16'h0001)
				st_nxt = prog_word.ecc ? ST_INIT : ST_IDLE;
		end
		ST_INIT: if (cnt_r == INIT_WORDS - 16'h0001) st_nxt = ST_IDLE;
		ST_IDLE: begin
			if (refresh_req)
				st_nxt = ST_REF;
			else if (|grant)
				st_nxt = ST_ROW;
		end
		ST_ROW: st_nxt = ST_COL;
		ST_COL: st_nxt = (cfg_r.ecc && (!cur_wr_r || rmw_r)) ? ST_CHK : ST_DONE;
		ST_CHK: begin
			if (rmw_r || (error_detect_in && correctable_in))
				st_nxt = ST_WB;
			else
				st_nxt = ST_DONE;
		end
		ST_WB: st_nxt = ST_DONE;
		ST_DONE: st_nxt = ST_IDLE;
		ST_REF: st_nxt = ST_IDLE;
		default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			st_r <= ST_PROG;
		else
			st_r <= st_nxt;
	end

	// Cycle counter for programming, warm-up and init
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cnt_r <= 16'h0000;
		else if (st_nxt != st_r)
			cnt_r <= 16'h0000;
		else
			cnt_r <= cnt_r + 16'h0001;
	end

	// Program bits shifted in from the strap pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			shift_r <= '0;
		else if (st_r == ST_PROG)
			shift_r <= {strap_program_in, shift_r[CTRL_W-1:1]};
	end

	// Solid strap levels select the default configurations
	always_comb begin
		if (&shift_r)
			prog_word = CFG_ECC_DEF;
		else if (~|shift_r)
			prog_word = CFG_NON_DEF;
		else
			prog_word = shift_r;
	end

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;

	// Configuration: loaded from the strap, then software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cfg_r <= CTRL_RST;
		else if (st_r == ST_WARM && cnt_r == 16'h0000)
			cfg_r <= prog_word;
		else if (wr_acc && paddr == OFF_CTRL)
			cfg_r <= pwdata[CTRL_W-1:0];
	end

	// Cycle attributes latched at grant
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_port_r <= 1'b0;
			last_port_r <= 1'b0;
			cur_wr_r <= 1'b0;
			rmw_r <= 1'b0;
		end else if (|grant) begin
			cur_port_r <= grant[1];
			last_port_r <= grant[1];
			cur_wr_r <= grant[1] ? port_b_req.wr : port_a_req.wr;
			rmw_r <= cfg_r.ecc & ~whole_word_write_in &
				(grant[1] ? port_b_req.wr : port_a_req.wr);
		end
	end

	// Error flags sampled in the check phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err_r <= 1'b0;
			corr_r <= 1'b0;
		end else if (st_r == ST_CHK) begin
			err_r <= error_detect_in;
			corr_r <= correctable_in;
		end
	end

	// Lock owner capture on the rising lock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_prev_r <= 1'b0;
			lock_port_r <= 1'b0;
		end else begin
			lock_prev_r <= lock_in;
			if (lock_in && !lock_prev_r)
				lock_port_r <= cur_port_r;
		end
	end

	// Acknowledge timing per port
	assign in_cycle = (st_r == ST_ROW) || (st_r == ST_COL) ||
		(st_r == ST_CHK) || (st_r == ST_WB) || (st_r == ST_DONE);
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			fin_pulse[i] = (st_r == ST_DONE) && (cur_port_r == i[0]);
			ack_pulse[i] = cfg_r.ecc && (cur_port_r == i[0]) &&
				(sync_sel[i] ? st_r == ST_COL : st_r == ST_DONE);
			go_pulse[i] = !cfg_r.ecc && (cur_port_r == i[0]) &&
				(sync_sel[i] ? st_r == ST_COL : st_r == ST_ROW);
		end
	end

	// Served and acknowledged flags, set wins over release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 2'b00;
			ackd_r <= 2'b00;
		end else begin
			done_r <= fin_pulse | (done_r & {port_b_req.req, port_a_req.req});
			ackd_r <= ack_pulse | (ackd_r & {port_b_req.req, port_a_req.req});
		end
	end

	assign port_a_transfer_ack = !cfg_r.ecc && (fin_pulse[0] || done_r[0]);
	assign port_b_transfer_ack = !cfg_r.ecc && (fin_pulse[1] || done_r[1]);
	assign port_a_ecc_ack = ack_pulse[0] || (cfg_r.ecc && cfg_r.xack && ackd_r[0]);
	assign port_b_ecc_ack = ack_pulse[1] || (cfg_r.ecc && cfg_r.xack && ackd_r[1]);
	assign port_a_early_go = go_pulse[0];
	assign port_b_early_go = go_pulse[1];
	assign fast_addr_latch_strobe = cfg_r.fast && grant[0];

	// Correction unit control
	assign zero_fill_cmd = (st_r == ST_INIT);
	assign check_latch_strobe = cfg_r.ecc && ((st_r == ST_CHK) ||
		(st_r == ST_WB) || (st_r == ST_COL && cur_wr_r && !rmw_r));
	assign all_bytes_out_enable = (st_r == ST_WARM) || (st_r == ST_INIT) ||
		(st_r == ST_REF) || (in_cycle && (!cur_wr_r || rmw_r));
	assign ram_write_en = (st_r == ST_INIT) ||
		(st_r == ST_COL && cur_wr_r && !rmw_r) ||
		(st_r == ST_WB && (!err_r || corr_r));

	// Error events; check phase never runs in refresh
	assign err_ev = cfg_r.ecc && (st_r == ST_CHK) && error_detect_in;
	assign unc_ev = err_ev && !correctable_in;
	assign init_ev = (st_r != ST_IDLE) && (st_nxt == ST_IDLE) &&
		((st_r == ST_INIT) || (st_r == ST_WARM));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			log_b_r <= 1'b1;
		else
			log_b_r <= !err_ev;
	end
	assign error_log_strobe_b = log_b_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			init_done_r <= 1'b0;
		else if (init_ev)
			init_done_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ecnt_r <= 16'h0000;
		else if (err_ev)
			ecnt_r <= ecnt_r + 16'h0001;
	end

	// Interrupt status, write one to clear, events win
	always_comb begin
		ev = '0;
		ev[IRQ_ERR_BIT] = err_ev;
		ev[IRQ_UNC_BIT] = unc_ev;
		ev[IRQ_INIT_BIT] = init_ev;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ist_r <= '0;
		else if (wr_acc && paddr == OFF_ISTAT)
			ist_r <= (ist_r & ~pwdata[IRQ_W-1:0]) | ev;
		else
			ist_r <= ist_r | ev;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			imask_r <= IMASK_RST;
		else if (wr_acc && paddr == OFF_IMASK)
			imask_r <= pwdata[IRQ_W-1:0];
	end
	assign irq = |(ist_r & imask_r);

	// APB read data and error prepared in the setup phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			unique case (paddr)
			OFF_CTRL: prdata_r[CTRL_W-1:0] <= cfg_r;
			OFF_STAT: prdata_r[7:0] <= {lock_owner, cur_port_r, lock_in,
				init_done_r, st_r};
			OFF_ISTAT: prdata_r[IRQ_W-1:0] <= ist_r;
			OFF_IMASK: prdata_r[IRQ_W-1:0] <= imask_r;
			OFF_ECNT: prdata_r[15:0] <= ecnt_r;
			default: pslverr_r <= 1'b1;
			endcase
		end
	end
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign pready = 1'b1;

	// Checks
	mode_xack_a: assert property ((port_a_transfer_ack || port_b_transfer_ack)
		|-> !cfg_r.ecc && (st_r == ST_DONE ||
		$past(port_a_transfer_ack || port_b_transfer_ack)))
		else $error("transfer ack outside plain mode or done");
	ack_style_a: assert property ((ack_pulse[0] && cfg_r.xack &&
		port_a_req.req) |=> port_a_ecc_ack)
		else $error("xack style ack not held");
	ack_time_a: assert property ((cfg_r.ecc && st_r == ST_COL &&
		!cur_port_r) |-> (port_a_ecc_ack == (cfg_r.sync_a ||
		(cfg_r.xack && ackd_r[0]))))
		else $error("early ack timing wrong");
	go_before_a: assert property ($rose(port_a_early_go) && !cfg_r.ecc
		|-> ##[1:2] port_a_transfer_ack)
		else $error("early go not followed by ack");
	zero_init_a: assert property (zero_fill_cmd |-> cfg_r.ecc &&
		ram_write_en && all_bytes_out_enable)
		else $error("zero fill outside ecc init");
	latch_chk_a: assert property ((st_r == ST_CHK && cfg_r.ecc)
		|-> check_latch_strobe)
		else $error("syndrome not latched");
	read_bytes_a: assert property ((st_r == ST_REF || (in_cycle &&
		!cur_wr_r)) |-> all_bytes_out_enable)
		else $error("bytes disabled in read or refresh");
	warm_len_a: assert property ($rose(st_r == ST_WARM) |->
		(all_bytes_out_enable && st_r == ST_WARM)[*8] ##1 st_r != ST_WARM)
		else $error("warm-up not eight cycles");
	log_pulse_a: assert property (err_ev |=> !error_log_strobe_b ##1
		error_log_strobe_b)
		else $error("log strobe not one clock low");
	no_ref_log_a: assert property ($past(st_r == ST_REF) |->
		error_log_strobe_b)
		else $error("log strobe in refresh");
	lock_out_a: assert property ((lock_in && $past(lock_in) &&
		lock_port_r == 1'b0) |-> !grant[1])
		else $error("locked out port served");
	no_wb_unc_a: assert property ((st_r == ST_CHK && error_detect_in &&
		!correctable_in) |=> !ram_write_en)
		else $error("write back on uncorrectable");
	fast_strobe_a: assert property (fast_addr_latch_strobe |->
		cfg_r.fast && st_r == ST_IDLE ##1 st_r == ST_ROW)
		else $error("fast latch strobe misplaced");

	read_cycle_c: cover property (st_r == ST_CHK ##1 st_r == ST_WB);
	lock_block_c: cover property (lock_in && req[1] && blocked[1]);
	refresh_c: cover property (st_r == ST_REF);
	log_c: cover property ($fell(error_log_strobe_b));
endmodule // dpe_ctrl
`default_nettype wire

// *** tb/dpe_ecc_model.sv ***
`default_nettype none
module dpe_ecc_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic check_latch_strobe,
	input wire logic inject_err,
	input wire logic inject_corr,
	output logic error_detect_in,
	output logic correctable_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tog_r <= 1'b0;
		end else begin
			tog_r <= !tog_r;
		end
	end
	// Flags valid only while latched, junk otherwise
	assign error_detect_in = check_latch_strobe ? inject_err : tog_r;
	assign correctable_in = check_latch_strobe ? inject_corr : !tog_r;
endmodule // dpe_ecc_model
`default_nettype wire

// *** tb/dual_port_dram_ecc_handshake_test.sv ***
`default_nettype none
module dual_port_dram_ecc_handshake_test import dpe_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, apb_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	dpe_req_t port_a_req, port_b_req;
	logic lock_in, refresh_req, whole_word_write_in, strap_program_in;
	logic error_detect_in, correctable_in, inj_err, inj_corr;
	logic port_a_transfer_ack, port_b_transfer_ack, port_a_ecc_ack;
	logic port_b_ecc_ack, port_a_early_go, port_b_early_go;
	logic fast_addr_latch_strobe, zero_fill_cmd, check_latch_strobe;
	logic all_bytes_out_enable, error_log_strobe_b, ram_write_en;
	int error_cnt, n_checks, lat, gop, n_go, n_we, n_dbm, n_chk, n_error_log_strobe;
	int n_ack, n_fast;
	logic [31:0] cf[4] = '{32'h1, 32'h5, 32'h3, 32'h9};
	int pt[4] = '{0, 0, 0, 1};
	int el[4] = '{4, 2, 4, 2};
	int ea[4] = '{1, 1, 4, 1};

	dpe_ctrl #(.INIT_WORDS(16'h0004)) i_dut (.*);
	dpe_ecc_model i_ecc (.clk(clk), .rst_b(rst_b),
		.check_latch_strobe(check_latch_strobe), .inject_err(inj_err),
		.inject_corr(inj_corr), .error_detect_in(error_detect_in),
		.correctable_in(correctable_in));

	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end

	function automatic int b1(input logic v);
		return int'(v === 1'b1);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		apb_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic s, input int exp_dbm);
		int nd;
		int nz;
		@(posedge clk);
		rst_b <= 1'b0;
		strap_program_in <= s;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		nd = 0;
		nz = 0;
		repeat (40) begin
			@(posedge clk);
			#1;
			nd += b1(all_bytes_out_enable);
			nz += b1(zero_fill_cmd);
		end
		chk("warm dbm", exp_dbm, nd);
		chk("zero fill", s ? 4 : 0, nz);
		apb(0, OFF_CTRL, 0);
		chk("strap cfg", s ? CFG_ECC_DEF : CFG_NON_DEF, rd);
		apb(0, OFF_IMASK, 0);
		chk("imask", IMASK_RST, rd);
	endtask

	task automatic access(input logic b, input logic wr, input int lim);
		logic ack;
		logic go;
		lat = -1;
		gop = -1;
		n_go = 0;
		n_we = 0;
		n_dbm = 0;
		n_chk = 0;
		n_error_log_strobe = 0;
		n_ack = 0;
		n_fast = 0;
		@(posedge clk);
		if (b) begin
			port_b_req <= {wr, 1'b1};
		end else begin
			port_a_req <= {wr, 1'b1};
		end
		for (int i = 0; i < lim; i++) begin
			#1;
			ack = b ? port_b_transfer_ack | port_b_ecc_ack
				: port_a_transfer_ack | port_a_ecc_ack;
			go = b ? port_b_early_go : port_a_early_go;
			if (b1(ack) && lat < 0) begin
				lat = i;
			end
			if (b1(go) && gop < 0) begin
				gop = i;
			end
			n_go += b1(go);
			n_ack += b1(ack);
			n_we += b1(ram_write_en);
			n_dbm += b1(all_bytes_out_enable);
			n_chk += b1(check_latch_strobe);
			n_error_log_strobe += b1(!error_log_strobe_b);
			n_fast += b1(fast_addr_latch_strobe);
			@(posedge clk);
		end
		port_a_req <= '0;
		port_b_req <= '0;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_nonecc();
		apb(1, OFF_CTRL, 32'h0);
		access(0, 1, 6);
		chk("xack lat", 3, lat);
		chk("xack held", 3, n_ack);
		chk("go pos async", 1, gop);
		chk("go count", 1, n_go);
		chk("write en", 1, n_we);
		chk("dbm write", 0, n_dbm);
		chk("chk strobe", 0, n_chk);
		apb(1, OFF_CTRL, 32'h8);
		access(1, 0, 6);
		chk("go pos sync", 2, gop);
		chk("b ack lat", 3, lat);
		chk("dbm read", 1, n_dbm > 0);
		chk("read we", 0, n_we);
	endtask

	task automatic t_lock();
		access(0, 0, 6);
		@(posedge clk);
		lock_in <= 1'b1;
		apb(0, OFF_STAT, 0);
		chk("lock stat", 32'h20, rd & 32'ha0);
		access(1, 0, 8);
		chk("locked out", 0, n_ack);
		access(0, 0, 6);
		chk("owner lat", 3, lat);
		@(posedge clk);
		lock_in <= 1'b0;
		access(1, 0, 6);
		chk("unlock lat", 3, lat);
	endtask

	task automatic t_ecc_ack();
		for (int k = 0; k < 4; k++) begin
			apb(1, OFF_CTRL, cf[k]);
			access(pt[k][0], 0, 8);
			chk("ecc ack lat", el[k], lat);
			chk("ecc ack len", ea[k], n_ack);
			chk("ecc go", 0, n_go);
			chk("ecc chk", 1, n_chk > 0);
		end
	endtask

	task automatic t_error();
		apb(1, OFF_CTRL, 32'h1);
		apb(1, OFF_ISTAT, 32'h7);
		inj_err <= 1'b1;
		access(0, 0, 8);
		chk("log pulse", 1, n_error_log_strobe);
		chk("wb en", 1, n_we);
		apb(0, OFF_ISTAT, 0);
		chk("istat corr", 32'h1, rd);
		chk("irq masked", 0, irq);
		apb(1, OFF_IMASK, 32'h1);
		#1;
		chk("irq on", 1, irq);
		apb(1, OFF_ISTAT, 32'h1);
		#1;
		chk("irq clr", 0, irq);
		inj_corr <= 1'b0;
		access(0, 0, 8);
		chk("no wb", 0, n_we);
		chk("log pulse u", 1, n_error_log_strobe);
		apb(0, OFF_ISTAT, 0);
		chk("istat unc", 32'h3, rd);
		apb(0, OFF_ECNT, 0);
		chk("err count", 2, rd);
		apb(1, OFF_ISTAT, 32'h7);
		inj_err <= 1'b0;
		inj_corr <= 1'b1;
		whole_word_write_in <= 1'b0;
		access(0, 1, 8);
		chk("rmw we", 1, n_we > 0);
		chk("rmw dbm", 1, n_dbm > 0);
		whole_word_write_in <= 1'b1;
	endtask

	task automatic t_refresh();
		n_dbm = 0;
		n_error_log_strobe = 0;
		@(posedge clk);
		refresh_req <= 1'b1;
		inj_err <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			#1;
			n_dbm += b1(all_bytes_out_enable);
			n_error_log_strobe += b1(!error_log_strobe_b);
			@(posedge clk);
			refresh_req <= 1'b0;
		end
		chk("ref dbm", 1, n_dbm > 0);
		chk("ref no log", 0, n_error_log_strobe);
		inj_err <= 1'b0;
	endtask

	task automatic t_fast();
		apb(1, OFF_CTRL, 32'h11);
		access(0, 0, 8);
		chk("fast a", 1, n_fast);
		access(1, 0, 8);
		chk("fast b", 0, n_fast);
		apb(0, 8'h20, 32'h0);
		chk("unmapped err", 1, apb_err);
		chk("unmapped rd", 0, rd);
	endtask

	initial begin
		#160000;
		error_cnt++;
		$display("unexpected timeout");
		finish_test();
	end

	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, lock_in, refresh_req} = '0;
		paddr = '0;
		pwdata = '0;
		port_a_req = '0;
		port_b_req = '0;
		whole_word_write_in = 1'b1;
		strap_program_in = 1'b0;
		inj_err = 1'b0;
		inj_corr = 1'b1;
		error_cnt = 0;
		n_checks = 0;
		do_reset(0, 8);
		t_nonecc();
		t_lock();
		do_reset(1, 12);
		t_ecc_ack();
		t_error();
		t_refresh();
		t_fast();
		finish_test();
	end
endmodule // dual_port_dram_ecc_handshake_test
`default_nettype wire
